// >>> hdl/mwc_pkg.sv
// Constants, field layout and period tables of the mode and watchdog control register.
// Assumes a 200 MHz system clock and a 16-bit SPI frame, MSB first.
package mwc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int CYCLES_PER_MS = MS_PS / CLK_PERIOD_PS;
  localparam int INIT_TIME_MS = 256;
  localparam int UV_TIME_MS = 256;
  localparam int MS_W = 14;

  localparam logic [1:0] ADDR_MODE_REG = 2'h0;
  localparam int ADDR_HI_POS = 15;
  localparam int ADDR_LO_POS = 14;
  localparam int FB_SEL_POS = 13;
  localparam int RO_POS = 12;
  localparam int WD_MSB = 11;
  localparam int WD_LSB = 6;
  localparam int OM_MSB = 5;
  localparam int OM_LSB = 3;
  localparam int SDM_POS = 2;
  localparam int EN_POS = 1;
  localparam int CM_POS = 0;
  localparam int FB_SEL_BITCNT = 2;

  typedef enum logic [2:0] {
    MWC_NORMAL = 3'h1,
    MWC_STANDBY = 3'h2,
    MWC_INIT_FLASH = 3'h3,
    MWC_SLEEP = 3'h4,
    MWC_INIT_NORMAL = 3'h5,
    MWC_FLASH = 3'h7
  } mwc_mode_t;

  localparam logic [3:0] WD_IDX_BAD = 4'hF;
  localparam logic [3:0] WD_IDX_LAST = 4'h9;
  localparam logic [9:0][5:0] WD_CODES = {6'h36, 6'h35, 6'h33, 6'h2D, 6'h24,
                                          6'h1B, 6'h14, 6'h12, 6'h0C, 6'h09};
  localparam logic [MS_W-1:0] WD_OFF_MS = 14'h0000;
  localparam logic [9:0][MS_W-1:0] WD_NORMAL_MS = {14'h0050, 14'h0048, 14'h0040,
    14'h0038, 14'h0030, 14'h0028, 14'h0020, 14'h0010, 14'h0008, 14'h0004};
  localparam logic [9:0][MS_W-1:0] WD_FLASH_MS = {14'h2000, 14'h1000, 14'h0800,
    14'h0400, 14'h0280, 14'h0140, 14'h00A0, 14'h0050, 14'h0028, 14'h0014};
  localparam logic [9:0][MS_W-1:0] WD_SLEEP_MS = {14'h0000, 14'h2000, 14'h1800,
    14'h1000, 14'h0C00, 14'h0800, 14'h0400, 14'h0280, 14'h0140, 14'h00A0};
endpackage

// >>> hdl/mwc_wd_timer.sv
// Millisecond prescaler and watchdog down-counter.
// Assumes restart is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module mwc_wd_timer #(
  parameter int CYCLES_PER_MS = mwc_pkg::CYCLES_PER_MS
) (
  input wire logic clk, // System clock
  input wire logic reset_output_n, // Async reset, active low
  input wire logic restart, // Reload pulse
  input wire logic [13:0] load_ms, // Period, zero means off
  output logic ms_tick, // One-cycle pulse each ms
  output logic expired, // One-cycle pulse on overflow
  output logic running // Watchdog is counting
);
  logic [31:0] pre;
  logic [13:0] remain;

  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      pre <= 32'h0;
      ms_tick <= 1'b0;
    end
    else if (pre == 32'(CYCLES_PER_MS - 1))
    begin
      pre <= 32'h0;
      ms_tick <= 1'b1;
    end
    else
    begin
      pre <= pre + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // Runs from reset with the start-up window so a silent host is caught
  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      remain <= 14'(mwc_pkg::INIT_TIME_MS);
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (restart)
    begin
      remain <= load_ms;
      running <= (load_ms != mwc_pkg::WD_OFF_MS);
      expired <= 1'b0;
    end
    else if (running && ms_tick)
    begin
      if (remain <= 14'h1)
      begin
        running <= 1'b0;
        expired <= 1'b1;
      end
      else
      begin
        remain <= remain - 14'h1;
        expired <= 1'b0;
      end
    end
    else
    begin
      expired <= 1'b0;
    end
  end
endmodule

// >>> hdl/mwc_mode_watchdog_ctrl.sv
// Mode and watchdog control register behind a 16-bit SPI slave.
// Assumes SPI mode 0 with sck much slower than clk; status and diagnosis words are on clk.
`timescale 1ns/1ps
module mwc_mode_watchdog_ctrl #(
  parameter int CYCLES_PER_MS = mwc_pkg::CYCLES_PER_MS
) (
  input wire logic clk, // System clock
  input wire logic reset_output_n, // Async reset, active low
  input wire logic spi_sck, // SPI clock pin
  input wire logic spi_csn, // SPI chip select, active low
  input wire logic spi_mosi, // SPI data in
  output logic spi_miso, // SPI data out
  output logic spi_miso_oe, // High while driving miso
  input wire logic [11:0] status_word, // System status feedback
  input wire logic [11:0] system_diagnosis_feedback_word, // System diagnosis feedback
  input wire logic dev_flag_set, // Pulse from special mode logic
  input wire logic v1_undervoltage, // Regulator undervoltage pin
  output logic enable_out, // Global enable pin
  output logic can_active, // CAN forced active
  output logic [2:0] mode_code, // Accepted operating mode
  output logic [13:0] wd_period_ms, // Accepted period, zero is off
  output logic wd_running, // Watchdog counting
  output logic dev_flag, // Software development flag
  output logic sys_reset_req, // One-cycle reset request
  output logic fail_safe_req // Fail-safe request level
);
  logic sck_m, sck_s, sck_q, csn_m, csn_s, csn_q, mosi_m, mosi_s, uv_m, uv_s;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [4:0] bitcnt;
  logic sck_rise, sck_fall, csn_rise, frame_done;
  logic is_mode_addr, is_write, wd_ok, om_ok, accept, reject;
  logic [3:0] wd_idx;
  logic [13:0] next_period;
  logic restart, ms_tick, wd_expired;
  logic [8:0] uv_ms;

  function automatic logic [3:0] wd_index(input logic [5:0] code);
    wd_index = mwc_pkg::WD_IDX_BAD;
    for (int i = 0; i < 10; i++)
      if (mwc_pkg::WD_CODES[i] == code)
        wd_index = 4'(i);
  endfunction

  function automatic logic mode_legal(input logic [2:0] om);
    case (om)
      mwc_pkg::MWC_NORMAL, mwc_pkg::MWC_STANDBY, mwc_pkg::MWC_SLEEP,
      mwc_pkg::MWC_INIT_NORMAL, mwc_pkg::MWC_FLASH, mwc_pkg::MWC_INIT_FLASH:
        mode_legal = 1'b1;
      default:
        mode_legal = 1'b0;
    endcase
  endfunction

  function automatic logic [13:0] period_of(input logic [3:0] idx, input logic [2:0] om);
    case (om)
      mwc_pkg::MWC_NORMAL, mwc_pkg::MWC_INIT_NORMAL:
        period_of = mwc_pkg::WD_NORMAL_MS[idx];
      mwc_pkg::MWC_SLEEP:
        period_of = mwc_pkg::WD_SLEEP_MS[idx];
      mwc_pkg::MWC_STANDBY:
        period_of = (idx == mwc_pkg::WD_IDX_LAST) ? mwc_pkg::WD_OFF_MS
                                                  : mwc_pkg::WD_FLASH_MS[idx];
      default:
        period_of = mwc_pkg::WD_FLASH_MS[idx];
    endcase
  endfunction

  // Two-stage synchronisers; sck and csn also get a third stage for edge detection
  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      {sck_m, sck_s, sck_q} <= 3'h0;
      {csn_m, csn_s, csn_q} <= 3'h7;
      {mosi_m, mosi_s, uv_m, uv_s} <= 4'h0;
    end
    else
    begin
      sck_m <= spi_sck;
      sck_s <= sck_m;
      sck_q <= sck_s;
      csn_m <= spi_csn;
      csn_s <= csn_m;
      csn_q <= csn_s;
      mosi_m <= spi_mosi;
      mosi_s <= mosi_m;
      uv_m <= v1_undervoltage;
      uv_s <= uv_m;
    end
  end

  assign sck_rise = sck_s && !sck_q && !csn_s;
  assign sck_fall = !sck_s && sck_q && !csn_s;
  assign csn_rise = csn_s && !csn_q;
  // Frames of any other length are dropped whole
  assign frame_done = csn_rise && (bitcnt == 5'(mwc_pkg::FRAME_BITS));

  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      rx <= 16'h0000;
      bitcnt <= 5'h00;
    end
    else if (csn_s)
    begin
      bitcnt <= 5'h00;
    end
    else if (sck_rise)
    begin
      rx <= {rx[14:0], mosi_s};
      if (bitcnt != 5'h1F)
        bitcnt <= bitcnt + 5'h01;
    end
  end

  // Feedback word picked as soon as the select bit is in, so the data bits can follow it
  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
      tx <= 16'h0000;
    else if (csn_s)
      tx <= 16'h0000;
    else if (sck_rise && bitcnt == 5'(mwc_pkg::FB_SEL_BITCNT))
      tx <= {2'h0, (mosi_s ? system_diagnosis_feedback_word : status_word), 2'h0};
    else if (sck_fall)
      tx <= {tx[14:0], 1'b0};
  end

  assign spi_miso = tx[15];
  assign spi_miso_oe = !csn_s;

  assign is_mode_addr = ({rx[mwc_pkg::ADDR_HI_POS], rx[mwc_pkg::ADDR_LO_POS]}
                         == mwc_pkg::ADDR_MODE_REG);
  assign is_write = frame_done && is_mode_addr && !rx[mwc_pkg::RO_POS];
  assign wd_idx = wd_index(rx[mwc_pkg::WD_MSB:mwc_pkg::WD_LSB]);
  assign wd_ok = (wd_idx != mwc_pkg::WD_IDX_BAD);
  assign om_ok = mode_legal(rx[mwc_pkg::OM_MSB:mwc_pkg::OM_LSB]);
  assign accept = is_write && wd_ok && om_ok;
  assign reject = is_write && !(wd_ok && om_ok);
  assign next_period = period_of(wd_idx, rx[mwc_pkg::OM_MSB:mwc_pkg::OM_LSB]);
  assign restart = accept;

  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      mode_code <= 3'h0;
      wd_period_ms <= 14'(mwc_pkg::INIT_TIME_MS);
      enable_out <= 1'b0;
      can_active <= 1'b0;
    end
    else if (accept)
    begin
      mode_code <= rx[mwc_pkg::OM_MSB:mwc_pkg::OM_LSB];
      wd_period_ms <= next_period;
      enable_out <= rx[mwc_pkg::EN_POS];
      can_active <= rx[mwc_pkg::CM_POS];
    end
  end

  // Flag is only set from outside; a write can clear it, and a set pulse wins
  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
      dev_flag <= 1'b0;
    else if (dev_flag_set)
      dev_flag <= 1'b1;
    else if (accept && !rx[mwc_pkg::SDM_POS])
      dev_flag <= 1'b0;
  end

  // Code errors reset even in development mode; overflow does not
  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
      sys_reset_req <= 1'b0;
    else
      sys_reset_req <= reject || (wd_expired && !dev_flag);
  end

  always_ff @(posedge clk or negedge reset_output_n)
  begin
    if (!reset_output_n)
    begin
      uv_ms <= 9'h000;
      fail_safe_req <= 1'b0;
    end
    else if (!uv_s)
    begin
      uv_ms <= 9'h000;
      fail_safe_req <= 1'b0;
    end
    else if (ms_tick)
    begin
      if (uv_ms == 9'(mwc_pkg::UV_TIME_MS))
        fail_safe_req <= 1'b1;
      else
        uv_ms <= uv_ms + 9'h001;
    end
  end

  mwc_wd_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
    .clk(clk),
    .reset_output_n(reset_output_n),
    .restart(restart),
    .load_ms(next_period),
    .ms_tick(ms_tick),
    .expired(wd_expired),
    .running(wd_running)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_output_n);

  sequence s_good_write;
    accept;
  endsequence
  sequence s_outputs_taken;
    mode_code == $past(rx[mwc_pkg::OM_MSB:mwc_pkg::OM_LSB])
      && enable_out == $past(rx[mwc_pkg::EN_POS]) && can_active == $past(rx[mwc_pkg::CM_POS]);
  endsequence

  property p_wd_restart;
    s_good_write |=> (wd_running == (wd_period_ms != 14'h0000));
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");
  property p_mode_taken;
    s_good_write |=> s_outputs_taken;
  endproperty
  a_mode_taken: assert property (p_mode_taken) else $error("write not taken");
  property p_en_stable;
    !accept |=> $stable(enable_out) && $stable(can_active);
  endproperty
  a_en_stable: assert property (p_en_stable) else $error("enable moved");
  property p_cm_taken;
    accept |=> can_active == $past(rx[mwc_pkg::CM_POS]);
  endproperty
  a_cm_taken: assert property (p_cm_taken) else $error("CAN mode not taken");
  property p_bad_code;
    is_write && !wd_ok |=> sys_reset_req && $stable(wd_period_ms) && $stable(mode_code);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
  property p_reject_reset;
    reject |=> sys_reset_req && $stable(mode_code) && $stable(wd_period_ms);
  endproperty
  a_reject_reset: assert property (p_reject_reset) else $error("reject mishandled");
  property p_feedback;
    sck_rise && bitcnt == 5'(mwc_pkg::FB_SEL_BITCNT)
      |=> tx[13:2] == ($past(mosi_s) ? $past(system_diagnosis_feedback_word) : $past(status_word));
  endproperty
  a_feedback: assert property (p_feedback) else $error("wrong feedback");
  property p_read_only;
    frame_done && rx[mwc_pkg::RO_POS] |=> $stable(mode_code) && $stable(wd_period_ms);
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only wrote");
  property p_dev_quiet;
    dev_flag && wd_expired && !reject |=> !sys_reset_req;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("reset in dev mode");
  property p_mode_illegal;
    is_write && !mode_legal(rx[mwc_pkg::OM_MSB:mwc_pkg::OM_LSB]) |-> ##1 sys_reset_req;
  endproperty
  a_mode_illegal: assert property (p_mode_illegal) else $error("illegal mode kept");
endmodule

// >>> testbench/mwc_host_model.sv
// Host model: SPI master sending whole 16-bit frames, mode 0, 64 ns sck.
// Assumes the bench calls xfer only between frames.
`timescale 1ns/1ps
module mwc_host_model (
  input wire logic clk, // System clock, frame start only
  output logic spi_sck, // SPI clock, still outside frames
  output logic spi_csn, // Chip select, active low
  output logic spi_mosi, // Data to device
  input wire logic spi_miso // Data from device
);
  initial
  begin
    spi_sck = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  // Address bits lead the frame, MSB first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk);
    spi_csn = 1'b0;
    #32;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #32;
      spi_sck = 1'b1;
      rx = {rx[14:0], spi_miso};
      #32;
      spi_sck = 1'b0;
    end
    // Released line must not keep a stale level
    spi_mosi = ~spi_mosi;
    #32;
    spi_csn = 1'b1;
    #64;
  endtask
endmodule

// >>> testbench/mwc_mode_watchdog_ctrl_tb_top.sv
// Bench for the mode and watchdog control register, driven by a host model.
// Assumes a scaled millisecond of 20 clk cycles.
`timescale 1ns/1ps
module mwc_mode_watchdog_ctrl_tb_top;
  localparam int CPM = 20;
  logic clk, reset_output_n, spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
  logic dev_flag_set, v1_undervoltage, enable_out, can_active;
  logic wd_running, dev_flag, sys_reset_req, fail_safe_req;
  logic [11:0] status_word, system_diagnosis_feedback_word;
  logic [2:0] mode_code;
  logic [13:0] wd_period_ms;
  logic [15:0] rx;
  int errors, checks, cycles, rst_cnt;
  logic [5:0] wd_codes [10] = '{6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B, 6'h24, 6'h2D, 6'h33,
                                6'h35, 6'h36};
  logic [13:0] norm_ms [10] = '{14'h4, 14'h8, 14'h10, 14'h20, 14'h28, 14'h30, 14'h38,
                                14'h40, 14'h48, 14'h50};
  logic [2:0] modes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [13:0] mode_ms [6] = '{14'h50, 14'h0, 14'h2000, 14'h0, 14'h50, 14'h2000};
  logic [5:0] bad_wd [3] = '{6'h36, 6'h00, 6'h36};
  logic [2:0] bad_om [3] = '{3'h0, 3'h1, 3'h6};

  mwc_mode_watchdog_ctrl #(.CYCLES_PER_MS(CPM)) mwc_mode_watchdog_ctrl_inst (.clk, .reset_output_n,
    .spi_sck, .spi_csn, .spi_mosi, .spi_miso, .spi_miso_oe, .status_word, .system_diagnosis_feedback_word,
    .dev_flag_set, .v1_undervoltage, .enable_out, .can_active, .mode_code, .wd_period_ms,
    .wd_running, .dev_flag, .sys_reset_req, .fail_safe_req);
  mwc_host_model mwc_host_model_inst (.clk, .spi_sck, .spi_csn, .spi_mosi, .spi_miso);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (sys_reset_req === 1'b1)
      rst_cnt <= rst_cnt + 1;
    if (cycles == 40000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] fr(input logic feedback_select_bit, ro, input logic [5:0] wd,
                                     input logic [2:0] om, low);
    return {2'h0, feedback_select_bit, ro, wd, om, low};
  endfunction
  task automatic send(input logic [15:0] f);
    mwc_host_model_inst.xfer(f, rx);
  endtask
  task automatic apply_reset();
    @(negedge clk);
    reset_output_n = 1'b0;
    repeat (12) @(negedge clk);
    reset_output_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic check_out(input logic [2:0] om, input logic [13:0] ms, input logic [1:0] ec);
    cmp_val({13'h0, mode_code}, {13'h0, om});
    cmp_val({2'h0, wd_period_ms}, {2'h0, ms});
    cmp_val({14'h0, enable_out, can_active}, {14'h0, ec});
  endtask

  task automatic t_reset_values();
    check_out(3'h0, 14'h100, 2'h0);
    cmp_val({15'h0, wd_running}, 16'h1);
  endtask
  // First write lands well inside the start-up window
  task automatic t_periods();
    for (int i = 0; i < 10; i++)
    begin
      send(fr(1'b1, 1'b0, wd_codes[i], 3'h1, {1'b0, 2'(i)}));
      check_out(3'h1, norm_ms[i], 2'(i));
      cmp_val(rx, {4'h0, system_diagnosis_feedback_word});
    end
  endtask
  task automatic t_modes();
    send(fr(1'b0, 1'b0, 6'h09, 3'h2, 3'h3));
    check_out(3'h2, 14'h14, 2'h3);
    send(fr(1'b0, 1'b0, 6'h09, 3'h4, 3'h3));
    check_out(3'h4, 14'hA0, 2'h3);
    for (int i = 0; i < 6; i++)
    begin
      send(fr(1'b0, 1'b0, 6'h36, modes[i], 3'h3));
      check_out(modes[i], mode_ms[i], 2'h3);
      cmp_val({15'h0, wd_running}, {15'h0, mode_ms[i] != 14'h0});
      cmp_val(rx, {4'h0, status_word});
    end
  endtask
  task automatic t_illegal();
    int base;
    for (int i = 0; i < 3; i++)
    begin
      base = rst_cnt;
      send(fr(1'b0, 1'b0, bad_wd[i], bad_om[i], 3'h0));
      cmp_val(16'(rst_cnt - base), 16'h1);
      check_out(3'h7, 14'h2000, 2'h3);
    end
  endtask
  task automatic t_read_only();
    fork
      send(fr(1'b1, 1'b1, 6'h09, 3'h1, 3'h0));
      begin
        repeat (20) @(negedge clk);
        cmp_val({15'h0, spi_miso_oe}, 16'h1);
      end
    join
    cmp_val({15'h0, spi_miso_oe}, 16'h0);
    check_out(3'h7, 14'h2000, 2'h3);
    cmp_val(rx, {4'h0, system_diagnosis_feedback_word});
    send(16'h4000 | fr(1'b0, 1'b0, 6'h09, 3'h1, 3'h0));
    check_out(3'h7, 14'h2000, 2'h3);
  endtask
  task automatic t_dev_flag();
    int base;
    @(negedge clk);
    dev_flag_set = 1'b1;
    @(negedge clk);
    dev_flag_set = 1'b0;
    cmp_val({15'h0, dev_flag}, 16'h1);
    base = rst_cnt;
    // Short period, flag kept: expiry must stay silent
    send(fr(1'b0, 1'b0, 6'h09, 3'h1, 3'h4));
    repeat (200) @(negedge clk);
    cmp_val(16'(rst_cnt - base), 16'h0);
    cmp_val({15'h0, dev_flag}, 16'h1);
    send(fr(1'b0, 1'b0, 6'h09, 3'h1, 3'h0));
    cmp_val({15'h0, dev_flag}, 16'h0);
    base = rst_cnt;
    repeat (200) @(negedge clk);
    cmp_val({15'h0, rst_cnt != base}, 16'h1);
  endtask
  task automatic t_startup();
    int base;
    v1_undervoltage = 1'b1;
    apply_reset();
    base = rst_cnt;
    repeat (5000) @(negedge clk);
    cmp_val({15'h0, fail_safe_req}, 16'h0);
    cmp_val(16'(rst_cnt - base), 16'h0);
    repeat (300) @(negedge clk);
    cmp_val({15'h0, fail_safe_req}, 16'h1);
    cmp_val({15'h0, rst_cnt != base}, 16'h1);
  endtask

  initial
  begin
    reset_output_n = 1'b0;
    status_word = 12'hA5C;
    system_diagnosis_feedback_word = 12'h3B6;
    dev_flag_set = 1'b0;
    v1_undervoltage = 1'b0;
    apply_reset();
    t_reset_values();
    t_periods();
    t_modes();
    t_illegal();
    t_read_only();
    t_dev_flag();
    t_startup();
    print_verdict();
  end
endmodule
